// ### src/ocf_frame_decoder.sv
// Serial configuration frame decoder for output channels 3, 4 and 5
`timescale 1ns/1ps
// What this block does
// - Top four bits route frame by command
// - Access bit one means read only
// - Parity bit makes total ones odd
// - Bridge limit uses ch3 bit, shunt only
// - Freewheel bit selects active low-side drive
// - Overcurrent boost raises 1 mA and 5 mA gate current
// - Diag timer ignored when bridge one timers shared
// - Readback reports fixed or applied threshold
// - Six-bit overcurrent level stored and applied
// - Thermal and supply threshold adjustment stored
// - Mask time blanks detection or gates code
// - Restart policy: switching, or readout then switching
// - Bridge channels always need readout first
// - Bit 7 picks drain-source or shunt sensing
// - Bit 6 picks open-load test current
// - Two-bit gate current selection
// - Transistor type, side and output enable
// - Bridge one groups channels one to four
// - Peak-keep pair open-load mask reporting policy
// - Peak-keep pair one enable
// - Bridge two crossover gap setting
// - Channel five timer shared with six to eight
// - Bridge one timer sharing for channels three, four
module ocf_frame_decoder #(
  parameter logic [3:0] CMD_CH5 = ocf_pkg::CMD_CH5_DEFAULT
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Serial link pins
  input wire logic sclk_in,
  input wire logic csn_in,
  input wire logic mosi_in,
  output logic miso_out,
  // Context from neighbouring configuration
  input wire logic bridge_one_timer_sharing_in,
  input wire logic bridge_two_enable_in,
  input wire logic [5:0] applied_threshold_ch3_in,
  input wire logic [5:0] applied_threshold_ch4_in,
  input wire logic [5:0] applied_threshold_ch5_in,
  // Stored configurations
  output ocf_pkg::ocf_chan_type ch3_cfg_out,
  output ocf_pkg::ocf_chan_type ch4_cfg_out,
  output ocf_pkg::ocf_chan_type ch5_cfg_out,
  // Derived controls
  output ocf_pkg::ocf_chan_ctrl_type ch3_ctrl_out,
  output ocf_pkg::ocf_chan_ctrl_type ch4_ctrl_out,
  output ocf_pkg::ocf_chan_ctrl_type ch5_ctrl_out,
  output logic bridge_one_current_limit_on_out,
  output logic bridge_one_active_freewheel_out,
  output logic [1:0] gate_boost_ch3_out,
  output logic bridge_one_enable_out,
  output logic peak_keep_one_mask_policy_out,
  output logic peak_keep_one_enable_out,
  output logic [1:0] bridge_two_crossover_gap_out,
  output logic bridge_two_timer_sharing_out,
  // Frame status
  output logic parity_error_out,
  output logic frame_done_out
);
  import ocf_pkg::*;

  typedef struct packed {
    ocf_sync_type sclk;
    ocf_sync_type csn;
    logic [1:0] mosi;
    logic [5:0] bit_count;
    logic [31:0] shift_in;
    logic [31:0] shift_out;
    logic [31:0] response;
    logic miso;
    ocf_chan_type [NUM_SLOTS-1:0] cfg;
    ocf_chan_ctrl_type [NUM_SLOTS-1:0] ctrl;
    logic limit_on;
    logic [1:0] gate_boost;
    logic six_to_eight_share;
    logic parity_error;
    logic frame_done;
  } ocf_state_type;

  ocf_state_type s_q;
  ocf_state_type s_d;

  // Command code to storage slot; bit 2 flags a known code
  function automatic logic [2:0] ocf_slot(input logic [3:0] cmd);
    if (cmd == CMD_CH3) begin
      return {1'b1, SLOT_CH3};
    end else if (cmd == CMD_CH4) begin
      return {1'b1, SLOT_CH4};
    end else if (cmd == CMD_CH5) begin
      return {1'b1, SLOT_CH5};
    end
    return 3'h0;
  endfunction : ocf_slot

  // Gate current raised after overcurrent
  function automatic logic [1:0] ocf_boost(input logic [1:0] code, input logic global_boost);
    case (code)
      GATE_1MA: return global_boost ? GATE_20MA : GATE_5MA;
      GATE_5MA: return GATE_20MA;
      default: return code;
    endcase
  endfunction : ocf_boost

  // Rising edge at the end of a synchroniser
  function automatic logic ocf_rise(input ocf_sync_type s);
    return s.sync & ~s.prev;
  endfunction : ocf_rise

  // Falling edge at the end of a synchroniser
  function automatic logic ocf_fall(input ocf_sync_type s);
    return ~s.sync & s.prev;
  endfunction : ocf_fall

  // One when the count of ones is even
  function automatic logic ocf_even_ones(input logic [FRAME_BITS-2:0] w);
    return ~(^w);
  endfunction : ocf_even_ones

  function automatic logic [5:0] ocf_level_pick(input ocf_chan_type c, input logic [5:0] lvl);
    return c.threshold_readback_select ? lvl : c.overcurrent_level;
  endfunction : ocf_level_pick

  // Reply word: code, access bit, stored fields, picked level, parity
  function automatic logic [31:0] ocf_reply(input logic [31:0] w, input ocf_chan_type c,
                                            input logic [5:0] lvl);
    logic [31:0] r;
    r = WORD_RESET;
    r[CMD_MSB:CMD_LSB] = w[CMD_MSB:CMD_LSB];
    r[ACCESS_BIT] = w[ACCESS_BIT];
    r[FIELD_MSB:FIELD_LSB] = c;
    r[LEVEL_MSB:LEVEL_LSB] = ocf_level_pick(c, lvl);
    r[PARITY_BIT] = ocf_even_ones(r[FRAME_BITS-1:1]);
    return r;
  endfunction : ocf_reply

  // Per-channel behaviour from its stored fields
  function automatic ocf_chan_ctrl_type ocf_chan_ctrl(input ocf_chan_type c,
                                                      input logic [5:0] lvl,
                                                      input logic in_bridge,
                                                      input logic bridge_timer);
    ocf_chan_ctrl_type k;
    k.readback_threshold = ocf_level_pick(c, lvl);
    k.mask_blocks_detection = ~c.sense_method;
    k.restart_needs_readout = c.restart_policy | in_bridge;
    // Shared bridge timer overrides own field
    k.own_diag_timer = ~bridge_timer;
    return k;
  endfunction : ocf_chan_ctrl

  logic sclk_rise;
  logic sclk_fall;
  logic csn_fall;
  logic csn_rise;
  logic [2:0] slot;
  logic [31:0] frame;
  logic [31:0] reply;
  logic [5:0] applied [NUM_SLOTS];
  logic bridge_one_on;
  logic bridge_two_on;
  logic one_shared;

  always_comb begin
    s_d = s_q;
    reply = WORD_RESET;
    frame = s_q.shift_in;
    slot = ocf_slot(frame[CMD_MSB:CMD_LSB]);
    applied[SLOT_CH3] = applied_threshold_ch3_in;
    applied[SLOT_CH4] = applied_threshold_ch4_in;
    applied[SLOT_CH5] = applied_threshold_ch5_in;
    s_d.sclk = {sclk_in, s_q.sclk.meta, s_q.sclk.sync};
    s_d.csn = {csn_in, s_q.csn.meta, s_q.csn.sync};
    s_d.mosi = {mosi_in, s_q.mosi[1]};

    sclk_rise = ocf_rise(s_q.sclk);
    sclk_fall = ocf_fall(s_q.sclk);
    csn_fall = ocf_fall(s_q.csn);
    csn_rise = ocf_rise(s_q.csn);

    s_d.frame_done = 1'b0;
    if (csn_fall) begin
      s_d.bit_count = '0;
      s_d.shift_out = s_q.response;
      s_d.miso = s_q.response[FRAME_BITS-1];
    end else if (!s_q.csn.sync) begin
      if (sclk_rise) begin
        s_d.shift_in = {s_q.shift_in[FRAME_BITS-2:0], s_q.mosi[0]};
        if (s_q.bit_count != FRAME_COUNT_MAX) begin
          s_d.bit_count = s_q.bit_count + 6'h01;
        end
      end
      if (sclk_fall) begin
        s_d.shift_out = {s_q.shift_out[FRAME_BITS-2:0], 1'b0};
        s_d.miso = s_q.shift_out[FRAME_BITS-2];
      end
    end
    if (csn_rise && s_q.bit_count == FRAME_COUNT_FULL) begin
      s_d.frame_done = 1'b1;
      s_d.parity_error = frame[PARITY_BIT] != ocf_even_ones(frame[FRAME_BITS-1:1]);
      if (!s_d.parity_error && slot[2]) begin
        if (!frame[ACCESS_BIT]) begin
          s_d.cfg[slot[1:0]] = frame[FIELD_MSB:FIELD_LSB];
        end
        reply = ocf_reply(frame, s_d.cfg[slot[1:0]], applied[slot[1:0]]);
      end
      s_d.response = reply;
    end
    bridge_one_on = s_d.cfg[SLOT_CH4].extra[X_CH4_BRIDGE];
    bridge_two_on = bridge_two_enable_in;

    // Outputs 3 and 4 follow shared bridge one timers
    one_shared = bridge_one_on & ~bridge_one_timer_sharing_in;
    s_d.ctrl[SLOT_CH3] = ocf_chan_ctrl(s_d.cfg[SLOT_CH3], applied[SLOT_CH3], bridge_one_on,
                                       one_shared);
    s_d.ctrl[SLOT_CH4] = ocf_chan_ctrl(s_d.cfg[SLOT_CH4], applied[SLOT_CH4], bridge_one_on,
                                       one_shared);
    s_d.ctrl[SLOT_CH5] = ocf_chan_ctrl(s_d.cfg[SLOT_CH5], applied[SLOT_CH5], bridge_two_on,
                                       1'b0);

    s_d.six_to_eight_share = bridge_two_on & ~s_d.cfg[SLOT_CH5].extra[X_CH5_SHARING];
    // Limit valid only with shunt sensing
    s_d.limit_on = s_d.cfg[SLOT_CH3].extra[X_CH3_LIMIT] & s_d.cfg[SLOT_CH3].sense_method;
    s_d.gate_boost = ocf_boost(s_d.cfg[SLOT_CH3].gate_current,
                               s_d.cfg[SLOT_CH3].extra[X_CH3_BOOST]);
    if (!resetn_in) begin
      s_d = '0;
      s_d.sclk = '0;
      s_d.csn = 3'h7;
      s_d.cfg = {NUM_SLOTS{CHAN_RESET}};
      s_d.response = WORD_RESET;
      for (int i = 0; i < NUM_SLOTS; i++) begin
        s_d.ctrl[i].own_diag_timer = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    s_q <= s_d;
  end

  assign miso_out = s_q.miso;
  assign ch3_cfg_out = s_q.cfg[SLOT_CH3];
  assign ch4_cfg_out = s_q.cfg[SLOT_CH4];
  assign ch5_cfg_out = s_q.cfg[SLOT_CH5];
  assign ch3_ctrl_out = s_q.ctrl[SLOT_CH3];
  assign ch4_ctrl_out = s_q.ctrl[SLOT_CH4];
  assign ch5_ctrl_out = s_q.ctrl[SLOT_CH5];
  assign bridge_one_current_limit_on_out = s_q.limit_on;
  assign bridge_one_active_freewheel_out = s_q.cfg[SLOT_CH3].extra[X_CH3_FREEWHEEL];
  assign gate_boost_ch3_out = s_q.gate_boost;
  assign bridge_one_enable_out = s_q.cfg[SLOT_CH4].extra[X_CH4_BRIDGE];
  assign peak_keep_one_mask_policy_out = s_q.cfg[SLOT_CH4].extra[X_CH4_MASK];
  assign peak_keep_one_enable_out = s_q.cfg[SLOT_CH4].extra[X_CH4_PEAK];
  assign bridge_two_crossover_gap_out = s_q.cfg[SLOT_CH5].extra[X_CH5_GAP_MSB:X_CH5_GAP_LSB];
  assign bridge_two_timer_sharing_out = s_q.six_to_eight_share;
  assign parity_error_out = s_q.parity_error;
  assign frame_done_out = s_q.frame_done;

endmodule : ocf_frame_decoder

// ### src/ocf_pkg.sv
// Shared constants and types for the output-channel configuration frame decoder
package ocf_pkg;

  // Frame layout
  localparam int unsigned FRAME_BITS = 32;
  localparam logic [5:0] FRAME_COUNT_FULL = 6'h20;
  localparam logic [5:0] FRAME_COUNT_MAX = 6'h3f;
  localparam int unsigned CMD_MSB = 31;
  localparam int unsigned CMD_LSB = 28;
  localparam int unsigned ACCESS_BIT = 27;
  localparam int unsigned FIELD_MSB = 26;
  localparam int unsigned FIELD_LSB = 1;
  localparam int unsigned PARITY_BIT = 0;
  localparam int unsigned LEVEL_MSB = 20;
  localparam int unsigned LEVEL_LSB = 15;

  // Command codes
  localparam logic [3:0] CMD_CH3 = 4'h3;
  localparam logic [3:0] CMD_CH4 = 4'h4;
  localparam logic [3:0] CMD_CH5_DEFAULT = 4'h5;

  // Slots of the three stored configurations
  localparam logic [1:0] SLOT_CH3 = 2'h0;
  localparam logic [1:0] SLOT_CH4 = 2'h1;
  localparam logic [1:0] SLOT_CH5 = 2'h2;
  localparam int unsigned NUM_SLOTS = 3;

  // Positions inside the command-specific top field
  localparam int unsigned X_CH3_LIMIT = 2;
  localparam int unsigned X_CH3_FREEWHEEL = 1;
  localparam int unsigned X_CH3_BOOST = 0;
  localparam int unsigned X_CH4_BRIDGE = 2;
  localparam int unsigned X_CH4_MASK = 1;
  localparam int unsigned X_CH4_PEAK = 0;
  localparam int unsigned X_CH5_GAP_MSB = 2;
  localparam int unsigned X_CH5_GAP_LSB = 1;
  localparam int unsigned X_CH5_SHARING = 0;

  // Gate current codes
  localparam logic [1:0] GATE_EXT_RES = 2'h0;
  localparam logic [1:0] GATE_20MA = 2'h1;
  localparam logic [1:0] GATE_5MA = 2'h2;
  localparam logic [1:0] GATE_1MA = 2'h3;

  // Reset values
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // Bits [26:1] of a channel configuration frame
  typedef struct packed {
    logic [2:0] extra;
    logic [1:0] diag_timer;
    logic threshold_readback_select;
    logic [5:0] overcurrent_level;
    logic [1:0] thermal_adjust;
    logic supply_adjust;
    logic [2:0] overcurrent_mask_time;
    logic restart_policy;
    logic sense_method;
    logic open_load_current;
    logic [1:0] gate_current;
    logic transistor_type;
    logic side_select;
    logic output_enable;
  } ocf_chan_type;

  localparam ocf_chan_type CHAN_RESET = '0;

  // Link pin synchroniser: meta, sync, previous
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } ocf_sync_type;

  // Derived per-channel behaviour
  typedef struct packed {
    logic restart_needs_readout;
    logic own_diag_timer;
    logic mask_blocks_detection;
    logic [5:0] readback_threshold;
  } ocf_chan_ctrl_type;

endpackage : ocf_pkg

// ### tb/ocf_frame_decoder_properties.sv
// Concurrent checks on the frame decoder ports
`timescale 1ns/1ps
module ocf_frame_checker
  import ocf_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Context inputs
  input wire logic bridge_one_timer_sharing_in,
  input wire logic bridge_two_enable_in,
  input wire logic [5:0] applied_threshold_ch3_in,
  // Watched outputs
  input ocf_pkg::ocf_chan_type ch3_cfg_out,
  input ocf_pkg::ocf_chan_type ch4_cfg_out,
  input ocf_pkg::ocf_chan_type ch5_cfg_out,
  input ocf_pkg::ocf_chan_ctrl_type ch3_ctrl_out,
  input wire logic bridge_one_current_limit_on_out,
  input wire logic [1:0] gate_boost_ch3_out,
  input wire logic bridge_two_timer_sharing_out,
  input wire logic parity_error_out,
  input wire logic frame_done_out
);
  logic rst_q, b1s_q, b2e_q;
  logic [5:0] thr_q;
  // Previous-cycle copies of the context inputs
  always_ff @(posedge clock_in) begin
    {rst_q, b1s_q, b2e_q} <= {resetn_in, bridge_one_timer_sharing_in, bridge_two_enable_in};
    thr_q <= applied_threshold_ch3_in;
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  chk_done_single: assert property (frame_done_out |=> !frame_done_out)
    else $error("frame done longer than one cycle");
  chk_cfg_hold: assert property (!frame_done_out |->
    $stable(ch3_cfg_out) && $stable(ch4_cfg_out) && $stable(ch5_cfg_out))
    else $error("stored config changed without frame");
  chk_parity_hold: assert property (!frame_done_out |-> $stable(parity_error_out))
    else $error("parity flag changed without frame");
  chk_limit_shunt: assert property (rst_q |->
    bridge_one_current_limit_on_out == (ch3_cfg_out.extra[2] & ch3_cfg_out.sense_method))
    else $error("current limit wrong");
  chk_boost_code: assert property (rst_q |-> gate_boost_ch3_out ==
    ((ch3_cfg_out.gate_current == 2'h3) ? (ch3_cfg_out.extra[0] ? 2'h1 : 2'h2) :
    (ch3_cfg_out.gate_current == 2'h2) ? 2'h1 : ch3_cfg_out.gate_current))
    else $error("boosted gate code wrong");
  chk_readback_pick: assert property (rst_q |-> ch3_ctrl_out.readback_threshold ==
    (ch3_cfg_out.threshold_readback_select ? thr_q : ch3_cfg_out.overcurrent_level))
    else $error("readback threshold wrong");
  chk_restart_bridge: assert property (rst_q |->
    ch3_ctrl_out.restart_needs_readout == (ch3_cfg_out.restart_policy | ch4_cfg_out.extra[2]))
    else $error("restart policy wrong");
  chk_share_two: assert property (rst_q |->
    bridge_two_timer_sharing_out == (b2e_q & !ch5_cfg_out.extra[0]))
    else $error("bridge two timer sharing wrong");
  chk_own_timer: assert property (rst_q |->
    ch3_ctrl_out.own_diag_timer == !(ch4_cfg_out.extra[2] & !b1s_q))
    else $error("own timer flag wrong");
  chk_mask_dsm: assert property (rst_q |->
    ch3_ctrl_out.mask_blocks_detection == !ch3_cfg_out.sense_method)
    else $error("mask detection flag wrong");
  cov_good_frame: cover property (frame_done_out && !parity_error_out);
  cov_bad_frame: cover property (frame_done_out && parity_error_out);
  cov_limit_on: cover property (bridge_one_current_limit_on_out);
endmodule : ocf_frame_checker
bind ocf_frame_decoder ocf_frame_checker chk_u (.*);

// ### tb/ocf_host_model.sv
// Serial host model issuing 32-bit configuration frames
`timescale 1ns/1ps
module ocf_host_model (
  // Link pins
  output logic sclk_out,
  output logic csn_out,
  output logic mosi_out,
  input wire logic miso_in
);
  localparam int HALF_NS = 24;
  initial begin
    {sclk_out, csn_out, mosi_out} = 3'b010;
  end
  function automatic logic [31:0] mk(input logic [3:0] c, input logic r, input logic [25:0] f);
    mk = {c, r, f, 1'b0};
    mk[0] = ~^mk[31:1];
  endfunction : mk
  // Shift on fall, sample on rise, n bits
  task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] rx);
    rx = '0;
    csn_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi_out = w[31 - i];
      #HALF_NS sclk_out = 1'b1;
      rx = {rx[30:0], miso_in};
      #HALF_NS sclk_out = 1'b0;
    end
    #HALF_NS csn_out = 1'b1;
    // Released data line carries no stale bit
    mosi_out = ~mosi_out;
  endtask : xfer
endmodule : ocf_host_model

// ### tb/tb_top.sv
// Self-checking bench for the configuration frame decoder
`timescale 1ns/1ps
module tb_top;
  import ocf_pkg::*;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic b1s_in = 1'b1;
  logic b2e_in = 1'b0;
  logic [5:0] thr3 = 6'h2a;
  logic sclk, csn, mosi, miso, done, perr, lim, afw, b1e, pkm, pke, b2s, seen;
  logic [1:0] boost, gap, expb;
  ocf_chan_type c3, c4, c5, f;
  ocf_chan_ctrl_type k3, k4, k5;
  logic [31:0] rx, exp_w;
  int fails = 0;
  int num_checks = 0;
  always #2 clock_in = ~clock_in;
  ocf_host_model host_u (.sclk_out(sclk), .csn_out(csn), .mosi_out(mosi), .miso_in(miso));
  ocf_frame_decoder dut_u (.clock_in(clock_in), .resetn_in(resetn_in), .sclk_in(sclk),
    .csn_in(csn), .mosi_in(mosi), .miso_out(miso), .bridge_one_timer_sharing_in(b1s_in),
    .bridge_two_enable_in(b2e_in), .applied_threshold_ch3_in(thr3),
    .applied_threshold_ch4_in(thr3), .applied_threshold_ch5_in(thr3), .ch3_cfg_out(c3),
    .ch4_cfg_out(c4), .ch5_cfg_out(c5), .ch3_ctrl_out(k3), .ch4_ctrl_out(k4), .ch5_ctrl_out(k5),
    .bridge_one_current_limit_on_out(lim), .bridge_one_active_freewheel_out(afw),
    .gate_boost_ch3_out(boost), .bridge_one_enable_out(b1e),
    .peak_keep_one_mask_policy_out(pkm), .peak_keep_one_enable_out(pke),
    .bridge_two_crossover_gap_out(gap), .bridge_two_timer_sharing_out(b2s),
    .parity_error_out(perr), .frame_done_out(done));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  // One frame, then bounded watch for the completion pulse
  task automatic frame(input logic [31:0] w, input int n);
    seen = 1'b0;
    host_u.xfer(w, n, rx);
    repeat (40) begin
      @(posedge clock_in);
      if (done === 1'b1) seen = 1'b1;
    end
    @(negedge clock_in);
  endtask : frame
  task automatic send(input logic [3:0] c, input logic r, input logic [25:0] d);
    frame(host_u.mk(c, r, d), 32);
    chk(seen, 1'b1);
  endtask : send
  initial begin
    repeat (4) @(negedge clock_in);
    resetn_in = 1'b1;
    repeat (8) @(negedge clock_in);
    chk(c3, CHAN_RESET);
    f = 26'h14ac3e1;
    send(CMD_CH3, 1'b0, f);
    chk(c3, f);
    chk(afw, f.extra[1]);
    chk(k3.restart_needs_readout, f.restart_policy);
    send(CMD_CH3, 1'b1, 26'h3ffffff);
    chk(c3, f);
    chk(rx, host_u.mk(CMD_CH3, 1'b0, f));
    frame(host_u.mk(CMD_CH4, 1'b0, 26'h3ffffff) ^ 32'h1, 32);
    chk(perr, 1'b1);
    chk(c4, CHAN_RESET);
    frame(host_u.mk(CMD_CH4, 1'b0, 26'h3ffffff), 31);
    chk(seen, 1'b0);
    chk(c4, CHAN_RESET);
    b1s_in = 1'b0;
    f = '0;
    f.extra = 3'h7;
    send(CMD_CH4, 1'b0, f);
    chk(rx, 32'h0);
    chk(perr, 1'b0);
    chk({b1e, pkm, pke}, 3'h7);
    for (int i = 0; i < 8; i++) begin
      f = '0;
      f.extra = {1'b1, 1'b0, i[2]};
      f.gate_current = i[1:0];
      f.sense_method = i[0];
      expb = (i[1:0] == 2'h3) ? (i[2] ? 2'h1 : 2'h2) : (i[1:0] == 2'h2) ? 2'h1 : i[1:0];
      send(CMD_CH3, 1'b0, f);
      chk(boost, expb);
      chk(lim, i[0]);
      chk({k3.restart_needs_readout, k3.own_diag_timer}, 2'h2);
      chk(k4.restart_needs_readout, 1'b1);
      chk(k3.mask_blocks_detection, !i[0]);
    end
    b2e_in = 1'b1;
    for (int i = 0; i < 4; i++) begin
      f = '0;
      f.extra = {i[1:0], i[0]};
      send(CMD_CH5_DEFAULT, 1'b0, f);
      chk(gap, i[1:0]);
      chk(b2s, !i[0]);
      chk(c5, f);
      chk({k5.restart_needs_readout, k5.own_diag_timer}, 2'h3);
    end
    f = '0;
    f.threshold_readback_select = 1'b1;
    f.overcurrent_level = 6'h15;
    send(CMD_CH3, 1'b0, f);
    chk(k3.readback_threshold, thr3);
    f.overcurrent_level = thr3;
    exp_w = host_u.mk(CMD_CH3, 1'b0, f);
    f.threshold_readback_select = 1'b0;
    f.overcurrent_level = 6'h15;
    send(CMD_CH3, 1'b0, f);
    chk(rx, exp_w);
    chk(k3.readback_threshold, 6'h15);
    print_verdict();
  end
  initial begin
    #200000;
    fails++;
    print_verdict();
  end
endmodule : tb_top
